// ---- hw/ecc_support_pkg.sv ----
/*
  Constants for the error detection and buffer support unit.
  Assumes the support unit and the bench import this package whole.
*/
`default_nettype none
package ecc_support_pkg;
  // Register indices on the three index lines.
  localparam logic [2:0] IDX_CHECK = 3'h0;
  localparam logic [2:0] IDX_ERROR = 3'h1;
  localparam logic [2:0] IDX_LOW   = 3'h2;
  localparam logic [2:0] IDX_HIGH  = 3'h3;
  localparam logic [2:0] IDX_DRQ   = 3'h4;
  localparam logic [2:0] IDX_RDLT  = 3'h5;
  localparam logic [2:0] IDX_SDH   = 3'h6;
  localparam logic [2:0] IDX_CMD   = 3'h7;
  // Command byte fields.
  localparam logic [3:0] NIB_READ   = 4'h2;
  localparam logic [3:0] NIB_WRITE  = 4'h3;
  localparam logic [3:0] NIB_FORMAT = 4'h5;
  localparam int         LONG_BIT   = 1;
  // Sector, drive and head register fields.
  localparam int         SDH_ECC_BIT = 7;
  localparam int         SDH_SIZE_LO = 5;
  localparam logic [1:0] SIZE_128  = 2'h3;
  localparam logic [1:0] SIZE_256  = 2'h0;
  localparam logic [1:0] SIZE_512  = 2'h1;
  localparam logic [1:0] SIZE_1024 = 2'h2;
  // Falling tick edges that end a sector of each size.
  localparam logic [2:0] FALLS_256  = 3'h1;
  localparam logic [2:0] FALLS_512  = 3'h2;
  localparam logic [2:0] FALLS_1024 = 3'h4;
  localparam logic [2:0] EXTRA_BYTES = 3'h4;
  localparam logic [1:0] LAST_STEP   = 2'h3;
  // Reset values.
  localparam logic [7:0]  SDH_RESET  = 8'h00;
  localparam logic [7:0]  CMD_RESET  = 8'h00;
  localparam logic [17:0] SYNC_RESET = 18'h38d00;
  // Feedback tap masks, eight taps each, bit 0 always set.
  localparam logic [15:0] TAPS_A_DEF = 16'h162f;
  localparam logic [15:0] TAPS_B_DEF = 16'h8a3b;
  typedef enum logic [0:0] {
    SH_IDLE = 1'b0,
    SH_RUN  = 1'b1
  } shift_state_type;
endpackage
`default_nettype wire

// ---- hw/sync_2ff.sv ----
/*
  Two flip-flop synchroniser for a group of pin inputs.
  Assumes each bit is a level that is stable for several clocks.
*/
`timescale 1ns/10ps
`default_nettype none
module sync_2ff #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff <= RST;
      q       <= RST;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// ---- hw/ecc_shift16.sv ----
/*
  One 16-bit check shift register, one bit per step, LSB to MSB.
  Assumes step, din and the enables come from logic on clk.
*/
`timescale 1ns/10ps
`default_nettype none
module ecc_shift16 #(
  parameter logic [15:0] TAPS = 16'h0001
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        clear,
  input  wire logic        step,
  input  wire logic        din,
  input  wire logic        fb_en,
  input  wire logic        msb_en,
  output var  logic [15:0] q_ff
);
  logic        msb;
  logic [15:0] nxt_q;
  assign msb = q_ff[15] & msb_en;
  always_comb begin
    if (fb_en) begin
      nxt_q = {q_ff[14:0], 1'b0} ^ ((msb ^ din) ? TAPS : 16'h0000);
    end else begin
      // Without feedback the outgoing bit only compares with the input.
      nxt_q = {q_ff[14:0], msb ^ din};
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q_ff <= 16'h0000;
    end else if (clear) begin
      q_ff <= 16'h0000;
    end else if (step) begin
      q_ff <= nxt_q;
    end
  end
endmodule
`default_nettype wire

// ---- hw/ecc_support_unit.sv ----
/*
  Error detection and buffer support unit: check generator, sector
  size counter, command, error and sector/drive/head registers.
  Assumes strobes and selects come from pins and are synchronised here.
*/
// Contract
// - Processor select alone reaches internal registers; both low is illegal.
// - Index 0 check bytes, 2/3 write address loads, read wake/overflow clears.
// - Index 4,5 set latches; 6 sets/clears multi mode; 7 command/error.
// - Command decode uses upper nibble and bit 1 only.
// - Two 16-bit shift registers with eight taps give four bytes.
// - Check computation runs on sector buffer accesses while SDH bit 7 is set, until four bytes past overflow.
// - After overflow and last byte, feedback is forced to zero.
// - Check bytes are output after overflow without RAM select.
// - On reads the syndrome is formed and held until read.
// - Long mode makes the registers plain storage for four bytes.
// - Sector/drive/head register writable; bits 6:5 choose sector size.
// - Tick counter sets overflow on fall, or rise for 128 bytes.
// - Overflow drives the limit flag and sets the feedback latch.
// - Counter clears on reset, new command or overflow clear.
// - Drive selects carry bits 4:3 or 2:1 by hard/floppy.
// - Low three register bits drive output pins directly.
// - Command write clears counters, read latch, irq; loads long flag from bit 1.
// - Wake is immediate, or after overflow or four extra bytes.
// - Command register later holds error information for the host.
// - Bytes are captured at strobe end under three conditions.
// - Strobes are synchronised before shifting starts.
// - Two bits per clock, four clocks per byte after capture.
// - Wake stays set until the wake clear command.
// - Data request set by processor or write/format command; cleared at sector end, or four bytes later in long mode.
`timescale 1ns/10ps
`default_nettype none
module ecc_support_unit
  import ecc_support_pkg::*;
#(
  parameter logic [15:0] TAPS_A = TAPS_A_DEF,
  parameter logic [15:0] TAPS_B = TAPS_B_DEF
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       master_reset_in_b,
  input  wire logic       processor_select_b,
  input  wire logic       host_select_b,
  input  wire logic [2:0] register_index,
  input  wire logic       read_strobe_b,
  input  wire logic       write_strobe_b,
  input  wire logic [7:0] data_in,
  output var  logic [7:0] data_out,
  output var  logic       data_oe_b,
  input  wire logic       block_count_tick,
  input  wire logic       buffer_select_b,
  output var  logic       low_addr_load,
  output var  logic       high_addr_load,
  output var  logic       ram_select_b,
  output var  logic       counter_clear_out,
  output var  logic       buffer_limit_flag,
  output var  logic       processor_wake,
  output var  logic       host_data_request,
  output var  logic       host_irq,
  output var  logic       hard_floppy_sel,
  output var  logic       drive_sel_0,
  output var  logic       drive_sel_1,
  output var  logic [2:0] sdh_low,
  output var  logic       long_flag,
  output var  logic       multi_mode,
  output var  logic       read_latch
);
  logic [17:0] syn;
  logic        mr_s, ps_s, hs_s, rd_s, wr_s, tick_s, bcs_s;
  logic [2:0]  idx_s;
  logic [7:0]  din_s;
  logic        cp_sel, host_sel;
  logic        rd_q_ff, wr_q_ff, tick_q_ff, trig_q_ff;
  logic        acc_cp_ff, acc_host_ff, acc_bcs_ff;
  logic [2:0]  acc_idx_ff;
  logic [7:0]  wr_data_ff;
  logic        rd_end, wr_end, cp_rd, cp_wr, host_rd, host_wr;
  logic        cmd_wr, err_wr, sdh_wr, wake_clr, ovf_clr, is_wf;
  logic [7:0]  sdh_ff, cmd_ff, data_out_ff, sh_byte_ff;
  logic [2:0]  tick_cnt_ff, extra_ff, target;
  logic        count_overflow_ff, fb_inhibit_ff, four_extra, trig, trig_evt;
  logic        rise, fall, internal_buffer_select, cap, drive;
  logic        wake_ff, pend_ff, drq_ff, irq_ff, multi_ff, rdlt_ff;
  logic        low_ff, high_ff, cmr_ff, rcs_b_ff, oe_b_ff;
  logic        own_rd;
  logic [3:0]  clr_dly_ff;
  logic [1:0]  step_ff;
  shift_state_type state_ff;
  logic [15:0] reg_a, reg_b;
  logic [7:0]  chk_byte;
  logic        shifting;

  sync_2ff #(
    .W   (18),
    .RST (SYNC_RESET)
  ) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     ({master_reset_in_b, processor_select_b, host_select_b,
             register_index, read_strobe_b, write_strobe_b,
             block_count_tick, buffer_select_b, data_in}),
    .q     (syn)
  );
  assign mr_s   = ~syn[17];
  assign ps_s   = ~syn[16];
  assign hs_s   = ~syn[15];
  assign idx_s  = syn[14:12];
  assign rd_s   = ~syn[11];
  assign wr_s   = ~syn[10];
  assign tick_s = syn[9];
  assign bcs_s  = ~syn[8];
  assign din_s  = syn[7:0];

  assign cp_sel   = ps_s & ~hs_s;
  assign host_sel = hs_s & ~ps_s;

  // Address and data are held from the strobe's active cycles, so a
  // late change of the index lines cannot redirect the access.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_cp_ff   <= 1'b0;
      acc_host_ff <= 1'b0;
      acc_bcs_ff  <= 1'b0;
      acc_idx_ff  <= IDX_CHECK;
      wr_data_ff  <= 8'h00;
    end else if (rd_s | wr_s) begin
      acc_cp_ff   <= cp_sel;
      acc_host_ff <= host_sel;
      acc_bcs_ff  <= bcs_s;
      acc_idx_ff  <= idx_s;
      wr_data_ff  <= din_s;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_q_ff   <= 1'b0;
      wr_q_ff   <= 1'b0;
      tick_q_ff <= 1'b0;
      trig_q_ff <= 1'b0;
    end else begin
      rd_q_ff   <= rd_s;
      wr_q_ff   <= wr_s;
      tick_q_ff <= tick_s;
      trig_q_ff <= trig;
    end
  end

  assign rd_end  = rd_q_ff & ~rd_s;
  assign wr_end  = wr_q_ff & ~wr_s;
  assign cp_rd   = rd_end & acc_cp_ff;
  assign cp_wr   = wr_end & acc_cp_ff;
  assign host_rd = rd_end & acc_host_ff;
  assign host_wr = wr_end & acc_host_ff;

  assign wake_clr = cp_rd & (acc_idx_ff == IDX_LOW);
  assign ovf_clr = mr_s | cmd_wr | (cp_rd & (acc_idx_ff == IDX_HIGH));
  assign cmd_wr  = host_wr & (acc_idx_ff == IDX_CMD);
  assign err_wr  = cp_wr & (acc_idx_ff == IDX_CMD);
  assign sdh_wr  = host_wr & (acc_idx_ff == IDX_SDH);
  assign is_wf   = (wr_data_ff[7:4] == NIB_WRITE) |
                   (wr_data_ff[7:4] == NIB_FORMAT);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      low_ff  <= 1'b0;
      high_ff <= 1'b0;
      cmr_ff  <= 1'b0;
      clr_dly_ff <= 4'h0;
    end else begin
      low_ff  <= cp_wr & (acc_idx_ff == IDX_LOW);
      high_ff <= cp_wr & (acc_idx_ff == IDX_HIGH);
      cmr_ff  <= mr_s | cmd_wr;
      // The tick falls when the far counter obeys our clear; that fall
      // arrives late through the synchroniser and must not be counted.
      clr_dly_ff <= {clr_dly_ff[2:0], cmr_ff};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sdh_ff <= SDH_RESET;
    end else if (sdh_wr) begin
      sdh_ff <= wr_data_ff;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_ff <= CMD_RESET;
    end else if (cmd_wr | err_wr) begin
      cmd_ff <= wr_data_ff;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      long_flag <= 1'b0;
    end else if (cmd_wr) begin
      long_flag <= wr_data_ff[LONG_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      multi_ff <= 1'b0;
      rdlt_ff  <= 1'b0;
    end else begin
      if (cp_wr & (acc_idx_ff == IDX_SDH)) begin
        multi_ff <= 1'b1;
      end else if (mr_s | (cp_rd & (acc_idx_ff == IDX_SDH))) begin
        multi_ff <= 1'b0;
      end
      if (cp_wr & (acc_idx_ff == IDX_RDLT)) begin
        rdlt_ff <= 1'b1;
      end else if (mr_s | cmd_wr) begin
        rdlt_ff <= 1'b0;
      end
    end
  end

  assign rise = tick_s & ~tick_q_ff;
  assign fall = tick_q_ff & ~tick_s & ~(|clr_dly_ff);
  always_comb begin
    unique case (sdh_ff[SDH_SIZE_LO +: 2])
      SIZE_256: target = FALLS_256;
      SIZE_512: target = FALLS_512;
      SIZE_1024: target = FALLS_1024;
      SIZE_128: target = FALLS_256;
    endcase
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_ff <= 3'h0;
      count_overflow_ff     <= 1'b0;
    end else if (ovf_clr) begin
      tick_cnt_ff <= 3'h0;
      count_overflow_ff     <= 1'b0;
    end else if (sdh_ff[SDH_SIZE_LO +: 2] == SIZE_128) begin
      if (rise) begin
        count_overflow_ff <= 1'b1;
      end
    end else if (fall & ~count_overflow_ff) begin
      tick_cnt_ff <= tick_cnt_ff + 3'h1;
      if (tick_cnt_ff + 3'h1 == target) begin
        count_overflow_ff <= 1'b1;
      end
    end
  end

  ecc_shift16 #(
    .TAPS (TAPS_A)
  ) u_reg_a (
    .clk    (clk),
    .rst_b  (rst_b),
    .clear  (cmd_wr),
    .step   (shifting),
    .din    (sh_byte_ff[0]),
    .fb_en  (~fb_inhibit_ff),
    .msb_en (~(long_flag & fb_inhibit_ff)),
    .q_ff   (reg_a)
  );
  ecc_shift16 #(
    .TAPS (TAPS_B)
  ) u_reg_b (
    .clk    (clk),
    .rst_b  (rst_b),
    .clear  (cmd_wr),
    .step   (shifting),
    .din    (sh_byte_ff[1]),
    .fb_en  (~fb_inhibit_ff),
    .msb_en (~(long_flag & fb_inhibit_ff)),
    .q_ff   (reg_b)
  );
  // The bits that leave the MSBs in the next four steps form one byte.
  assign chk_byte = {reg_b[12], reg_a[12], reg_b[13], reg_a[13],
                     reg_b[14], reg_a[14], reg_b[15], reg_a[15]};

  assign internal_buffer_select = acc_bcs_ff | ((acc_cp_ff | acc_host_ff) &
                (acc_idx_ff == IDX_CHECK));
  assign four_extra = (extra_ff == EXTRA_BYTES);
  assign cap = ((rd_end | wr_end) & sdh_ff[SDH_ECC_BIT] & internal_buffer_select &
               ~four_extra) | (cp_rd & (acc_idx_ff == IDX_CHECK) &
               count_overflow_ff);
  assign shifting = (state_ff == SH_RUN);
  assign own_rd   = rd_end & (acc_idx_ff == IDX_CHECK) &
                    (acc_cp_ff | (acc_host_ff & count_overflow_ff));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff   <= SH_IDLE;
      step_ff    <= 2'h0;
      sh_byte_ff <= 8'h00;
    end else begin
      unique case (state_ff)
        SH_IDLE: begin
          if (cap) begin
            state_ff   <= SH_RUN;
            step_ff    <= 2'h0;
            // A read of our own port recirculates the byte we drove.
            sh_byte_ff <= own_rd ? data_out_ff : wr_data_ff;
          end
        end
        SH_RUN: begin
          sh_byte_ff <= {2'h0, sh_byte_ff[7:2]};
          step_ff    <= step_ff + 2'h1;
          if (step_ff == LAST_STEP) begin
            state_ff <= SH_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fb_inhibit_ff <= 1'b0;
      extra_ff      <= 3'h0;
    end else if (ovf_clr) begin
      fb_inhibit_ff <= 1'b0;
      extra_ff      <= 3'h0;
    end else begin
      if (count_overflow_ff & ~shifting & ~cap) begin
        fb_inhibit_ff <= 1'b1;
      end
      if (fb_inhibit_ff & cap & ~four_extra) begin
        extra_ff <= extra_ff + 3'h1;
      end
    end
  end

  assign trig     = long_flag ? four_extra : count_overflow_ff;
  assign trig_evt = trig & ~trig_q_ff;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_ff <= 1'b0;
      pend_ff <= 1'b0;
    end else begin
      if (mr_s | (cmd_wr & ~is_wf) | (pend_ff & trig)) begin
        wake_ff <= 1'b1;
      end else if (wake_clr) begin
        wake_ff <= 1'b0;
      end
      if (cmd_wr & is_wf) begin
        pend_ff <= 1'b1;
      end else if (mr_s | cmd_wr | trig) begin
        pend_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      drq_ff <= 1'b0;
    end else if ((cp_wr & (acc_idx_ff == IDX_DRQ)) | (cmd_wr & is_wf)) begin
      drq_ff <= 1'b1;
    end else if (mr_s | trig_evt) begin
      drq_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_ff <= 1'b0;
    end else if (err_wr) begin
      irq_ff <= 1'b1;
    end else if (mr_s | cmd_wr) begin
      irq_ff <= 1'b0;
    end
  end

  assign drive = rd_s & ((cp_sel & ((idx_s == IDX_CHECK) |
                 (idx_s == IDX_CMD))) | (host_sel & (idx_s == IDX_ERROR)) |
                 (host_sel & (idx_s == IDX_CHECK) & count_overflow_ff));
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      data_out_ff <= 8'h00;
      oe_b_ff     <= 1'b1;
      rcs_b_ff    <= 1'b1;
    end else begin
      oe_b_ff  <= ~drive;
      rcs_b_ff <= ~(~count_overflow_ff & ((host_sel & (idx_s == IDX_CHECK)) | bcs_s));
      if (drive) begin
        data_out_ff <= (idx_s == IDX_CHECK) ? chk_byte : cmd_ff;
      end
    end
  end

  assign data_out          = data_out_ff;
  assign data_oe_b         = oe_b_ff;
  assign ram_select_b      = rcs_b_ff;
  assign low_addr_load     = low_ff;
  assign high_addr_load    = high_ff;
  assign counter_clear_out = cmr_ff;
  assign buffer_limit_flag = count_overflow_ff;
  assign processor_wake    = wake_ff;
  assign host_data_request = drq_ff;
  assign host_irq          = irq_ff;
  assign multi_mode        = multi_ff;
  assign read_latch        = rdlt_ff;
  assign hard_floppy_sel = ~(sdh_ff[4] & sdh_ff[3]);
  assign drive_sel_1     = hard_floppy_sel ? sdh_ff[4] : sdh_ff[2];
  assign drive_sel_0     = hard_floppy_sel ? sdh_ff[3] : sdh_ff[1];
  assign sdh_low = sdh_ff[2:0];

  chk_no_select: assert property (@(posedge clk) disable iff (!rst_b)
    !(ps_s ^ hs_s) |=> data_oe_b)
    else $error("Bus driven without a single select.");
  chk_low_load: assert property (@(posedge clk) disable iff (!rst_b)
    (cp_wr && acc_idx_ff == IDX_LOW) |=> low_addr_load ##1 !low_addr_load)
    else $error("Low address load pulse wrong.");
  chk_multi_clear: assert property (@(posedge clk) disable iff (!rst_b)
    (cp_rd && acc_idx_ff == IDX_SDH) |=> !multi_mode)
    else $error("Multiple mode not cleared.");
  chk_write_drq: assert property (@(posedge clk) disable iff (!rst_b)
    (cmd_wr && wr_data_ff[7:4] == NIB_WRITE) |=> host_data_request)
    else $error("Write command did not request data.");
  chk_byte_steps: assert property (@(posedge clk) disable iff (!rst_b)
    (cap && !shifting) |=> shifting[*4] ##1 !shifting)
    else $error("Byte did not take four steps.");
  chk_inhibit_cause: assert property (@(posedge clk) disable iff (!rst_b)
    fb_inhibit_ff |-> buffer_limit_flag)
    else $error("Feedback inhibited without overflow.");
  chk_small_sector: assert property (@(posedge clk) disable iff (!rst_b)
    (sdh_ff[6:5] == SIZE_128 && rise && !ovf_clr) |=> buffer_limit_flag)
    else $error("Small sector did not overflow on rise.");
  chk_cmd_clears: assert property (@(posedge clk) disable iff (!rst_b)
    cmd_wr |=> !buffer_limit_flag && counter_clear_out && !host_irq
      && !read_latch)
    else $error("Command write did not clear state.");
  chk_wake_hold: assert property (@(posedge clk) disable iff (!rst_b)
    (processor_wake && !wake_clr) |=> processor_wake)
    else $error("Wake dropped without clear command.");
  cov_overflow: cover property (@(posedge clk) disable iff (!rst_b)
    $rose(buffer_limit_flag));
  cov_extra: cover property (@(posedge clk) disable iff (!rst_b)
    $rose(four_extra) && long_flag);
  cov_check_read: cover property (@(posedge clk) disable iff (!rst_b)
    cp_rd && acc_idx_ff == IDX_CHECK && fb_inhibit_ff);
endmodule
`default_nettype wire

// ---- bench/buffer_side_model.sv ----
/*
  Model of the external buffer address counter beside the support unit.
  Assumes each buffer access is one low pulse of buffer_select_b.
*/
`timescale 1ns/10ps
`default_nettype none
module buffer_side_model (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic buffer_select_b,
  input  wire logic counter_clear_out,
  output var  logic block_count_tick
);
  logic [9:0] addr_ff;
  logic       sel_ff;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_ff <= 10'h000;
      sel_ff  <= 1'b1;
    end else begin
      sel_ff <= buffer_select_b;
      if (counter_clear_out) begin
        addr_ff <= 10'h000;
      end else if (buffer_select_b && !sel_ff) begin
        addr_ff <= addr_ff + 10'h001;
      end
    end
  end
  assign block_count_tick = addr_ff[7];
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
/*
  Self-checking bench for the error detection support unit.
  Assumes the buffer side model stands in for the address counters.
*/
`timescale 1ns/10ps
`default_nettype none
module tb
  import ecc_support_pkg::*;
;
  logic        clk, rst_b, master_reset_in_b, processor_select_b;
  logic        host_select_b, read_strobe_b, write_strobe_b;
  logic        buffer_select_b, block_count_tick, data_oe_b;
  logic        low_addr_load, high_addr_load, ram_select_b;
  logic        counter_clear_out, buffer_limit_flag, processor_wake;
  logic        host_data_request, host_irq, hard_floppy_sel;
  logic        drive_sel_0, drive_sel_1, long_flag, multi_mode, read_latch;
  logic [2:0]  register_index, sdh_low;
  logic [7:0]  data_in, data_out, rd, c, e;
  logic [31:0] seed, ref_r;
  int          bad_count, num_checks, n_lo, n_hi, n_cmr;
  logic [7:0]  sdhs [5] = '{8'he0, 8'h80, 8'ha0, 8'hc0, 8'he0};
  logic [7:0]  cmdv [5] = '{8'h30, 8'h50, 8'h30, 8'h30, 8'h32};
  logic [7:0]  nibs [4] = '{8'h20, 8'h30, 8'h50, 8'h10};
  int          lens [5] = '{128, 256, 512, 1024, 128};

  ecc_support_unit i_ecc_support_unit (.*);
  buffer_side_model i_buffer_side_model (.*);

  always #5 clk = ~clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] dsel(input logic [7:0] v);
    logic h;
    h = !(v[4] && v[3]);
    return {2'h0, h, h ? v[4:3] : v[2:1], v[2:0]};
  endfunction

  // Reference check: one byte is four steps, LSB bit pair first.
  function automatic logic [31:0] crc_step(input logic [31:0] r,
                                           input logic [7:0]  b);
    for (int j = 0; j < 4; j++) begin
      r[15:0]  = {r[14:0], 1'b0} ^
                 ((r[15] ^ b[2*j]) ? TAPS_A_DEF : 16'h0000);
      r[31:16] = {r[30:16], 1'b0} ^
                 ((r[31] ^ b[2*j+1]) ? TAPS_B_DEF : 16'h0000);
    end
    return r;
  endfunction

  // Bits leave the two MSBs in step order, register A first.
  function automatic logic [7:0] ck_byte(input logic [31:0] r);
    logic [7:0] b;
    for (int j = 0; j < 4; j++) begin
      b[2*j]   = r[15-j];
      b[2*j+1] = r[31-j];
    end
    return b;
  endfunction

  task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] g);
    num_checks++;
    if (g !== x) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, x, g);
    end
  endtask

  // One strobe cycle; selects and data are held past the strobe's end.
  task automatic acc(input logic [1:0] sel_b, input logic [2:0] ix,
                     input logic wr, input logic [7:0] d, input logic bs);
    @(posedge clk);
    {processor_select_b, host_select_b} <= sel_b;
    register_index  <= ix;
    data_in         <= d;
    buffer_select_b <= !bs;
    write_strobe_b  <= !wr;
    read_strobe_b   <= wr;
    repeat (5) @(posedge clk);
    rd = data_out;
    write_strobe_b <= 1'b1;
    read_strobe_b  <= 1'b1;
    n_lo = 0;
    n_hi = 0;
    n_cmr = 0;
    repeat (8) begin
      @(posedge clk);
      n_lo += low_addr_load;
      n_hi += high_addr_load;
      n_cmr += counter_clear_out;
    end
    {processor_select_b, host_select_b} <= 2'b11;
    buffer_select_b <= 1'b1;
    data_in         <= ~d;
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge clk);
    bad_count++;
    complete_run();
  end

  initial begin
    {clk, rst_b, master_reset_in_b, processor_select_b} = 4'h3;
    {host_select_b, read_strobe_b, write_strobe_b, buffer_select_b} = 4'hf;
    register_index = 3'h0;
    data_in = 8'h00;
    seed = 32'h1728c493;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk("rst_hi", 8'h07, {data_oe_b, ram_select_b, hard_floppy_sel});
    chk("rst_lo", 8'h00, {processor_wake, buffer_limit_flag, host_irq});
    master_reset_in_b <= 1'b0;
    repeat (4) @(posedge clk);
    master_reset_in_b <= 1'b1;
    repeat (6) @(posedge clk);
    acc(2'b01, IDX_DRQ, 1, 8'h00, 0);
    chk("drq_set", 8'h01, host_data_request);
    chk("wake_hold", 8'h01, processor_wake);
    acc(2'b01, IDX_LOW, 0, 8'h00, 0);
    chk("wake_clr", 8'h00, processor_wake);
    acc(2'b01, IDX_LOW, 1, 8'h00, 0);
    chk("lo_pulse", 8'h10, {n_lo[3:0], n_hi[3:0]});
    acc(2'b01, IDX_HIGH, 1, 8'h00, 0);
    chk("hi_pulse", 8'h01, {n_lo[3:0], n_hi[3:0]});
    acc(2'b01, IDX_SDH, 1, 8'h00, 0);
    chk("multi_set", 8'h01, multi_mode);
    acc(2'b01, IDX_SDH, 0, 8'h00, 0);
    chk("multi_clr", 8'h00, multi_mode);
    seed = lfsr(seed);
    e = seed[7:0];
    acc(2'b01, IDX_CMD, 1, e, 0);
    chk("irq_set", 8'h01, host_irq);
    acc(2'b10, IDX_ERROR, 0, 8'h00, 0);
    chk("err_rd", e, rd);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      c = (i == 0) ? 8'h18 : (i == 1) ? 8'h06 : seed[7:0];
      acc(2'b10, IDX_SDH, 1, c, 0);
      chk("sdh_pins", dsel(c), {2'h0, hard_floppy_sel, drive_sel_1,
          drive_sel_0, sdh_low});
    end
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      c = {nibs[i][7:4], seed[3:0]};
      acc(2'b01, IDX_LOW, 0, 8'h00, 0);
      acc(2'b01, IDX_RDLT, 1, 8'h00, 0);
      acc(2'b10, IDX_CMD, 1, c, 0);
      chk("cmr", 8'h01, n_cmr[7:0]);
      chk("cmd_fx", {5'h0, c[1], 2'h0},
          {long_flag, read_latch, host_irq});
      chk("wake", {7'h0, i == 0 || i == 3}, processor_wake);
      if (i == 1 || i == 2)
        chk("drq_cmd", 8'h01, host_data_request);
      acc(2'b01, IDX_CMD, 0, 8'h00, 0);
      chk("cmd_rd", c, rd);
    end
    for (int i = 0; i < 5; i++) begin
      acc(2'b01, IDX_LOW, 0, 8'h00, 0);
      acc(2'b10, IDX_SDH, 1, sdhs[i], 0);
      acc(2'b10, IDX_CMD, 1, cmdv[i], 0);
      ref_r = 32'h0;
      for (int k = 1; k <= lens[i] + 4 * cmdv[i][1]; k++) begin
        seed = lfsr(seed);
        if (k <= lens[i])
          ref_r = crc_step(ref_r, seed[7:0]);
        acc(2'b11, IDX_CHECK, 1, seed[7:0], 1);
        if (k == lens[i] - 1)
          chk("lim_early", 8'h00, buffer_limit_flag);
        if (k == lens[i]) begin
          repeat (8) @(posedge clk);
          chk("ovf", {5'h0, 1'b1, !cmdv[i][1], cmdv[i][1]}, {buffer_limit_flag,
              processor_wake, host_data_request});
        end
      end
      repeat (8) @(posedge clk);
      chk("sect_end", 8'h06, {buffer_limit_flag, processor_wake,
          host_data_request});
      for (int j = 0; j < 4 && !cmdv[i][1]; j++) begin
        acc(2'b01, IDX_CHECK, 0, 8'h00, 0);
        chk("chk_byte", ck_byte(ref_r), rd);
        ref_r = {ref_r[27:16], 4'h0, ref_r[11:0], 4'h0};
      end
      acc(2'b01, IDX_HIGH, 0, 8'h00, 0);
      chk("ovf_clr", 8'h00, buffer_limit_flag);
    end
    for (int s = 0; s < 2; s++) begin
      acc(s ? 2'b11 : 2'b10, IDX_RDLT, 1, 8'h00, 0);
      chk("no_sel", 8'h00, read_latch);
    end
    complete_run();
  end
endmodule
`default_nettype wire
